// ==== qdp_pkg.sv ====
/*
  qdp_pkg: constants and types for the quad dac power and wake control.
  assumes a 100 MHz clock and a separate decoder that presents commands.
*/
package qdp_pkg;
  // ==========================================================
  // command and address codes
  localparam logic [3:0] QDP_CMD_WR_IN = 4'h0;
  localparam logic [3:0] QDP_CMD_UPD_N = 4'h1;
  localparam logic [3:0] QDP_CMD_WR_UPD_ALL = 4'h2;
  localparam logic [3:0] QDP_CMD_WR_UPD_N = 4'h3;
  localparam logic [3:0] QDP_CMD_PD_N = 4'h4;
  localparam logic [3:0] QDP_CMD_PD_CHIP = 4'h5;
  localparam logic [3:0] QDP_CMD_REF_INT = 4'h6;
  localparam logic [3:0] QDP_CMD_REF_EXT = 4'h7;
  localparam logic [3:0] QDP_CMD_NOP = 4'hf;
  localparam logic [3:0] QDP_ADDR_ALL = 4'hf;
  localparam int QDP_NCH = 4;
  // ==========================================================
  // timing
  localparam int QDP_CLK_MHZ = 100;
  localparam int QDP_WAKE_SHORT_US = 10;
  localparam int QDP_WAKE_LONG_US = 12;
  localparam int QDP_WAKE_SHORT_CYC = QDP_WAKE_SHORT_US * QDP_CLK_MHZ;
  localparam int QDP_WAKE_LONG_CYC = QDP_WAKE_LONG_US * QDP_CLK_MHZ;
  localparam int QDP_CNT_W = 11;
  // ==========================================================
  // reset values
  localparam logic [3:0] QDP_PD_RST = 4'h0;
  localparam logic QDP_REF_ON_RST = 1'b1;
  localparam logic QDP_REF_BY_EXT_RST = 1'b0;
  localparam logic [2:0] QDP_SYNC_RST = 3'h7;
  typedef enum logic [1:0] {
    QDP_REF_ON = 2'b00,
    QDP_REF_OFF_EXT = 2'b01,
    QDP_REF_OFF_CHIP = 2'b10
  } qdp_ref_t;
endpackage : qdp_pkg

// ==== qdp_wake_timer.sv ====
/*
  qdp_wake_timer: one settle counter per channel.
  assumes start is a one-cycle pulse from the power control on the same clock.
*/
`timescale 1ns/1ps
module qdp_wake_timer
  import qdp_pkg::*;
(
  input wire logic clk,
  input wire logic rst_b,
  input wire logic start,
  input wire logic long_wait,
  input wire logic abort,
  output logic settled
);
  logic [QDP_CNT_W-1:0] cnt_q;
  // ==========================================================
  // countdown
  always_ff @(posedge clk or negedge rst_b)
  begin
    if (!rst_b)
    begin
      cnt_q <= '0;
    end
    else if (abort)
    begin
      cnt_q <= '0;
    end
    else if (start)
    begin
      cnt_q <= long_wait ? QDP_CNT_W'(QDP_WAKE_LONG_CYC) : QDP_CNT_W'(QDP_WAKE_SHORT_CYC);
    end
    else if (cnt_q != '0)
    begin
      cnt_q <= cnt_q - QDP_CNT_W'(1);
    end
  end
  // taken from the count alone, so the low time is exactly the programmed delay
  assign settled = (cnt_q == '0);
endmodule : qdp_wake_timer

// ==== qdp_power_ctrl.sv ====
/*
  qdp_power_ctrl: power state of four channels, bias and internal reference.
  assumes cmd_valid pulses one cycle per executed three-byte command with
  cmd_code and cmd_addr stable; the load pin is asynchronous and active low.
*/
`timescale 1ns/1ps
module qdp_power_ctrl
  import qdp_pkg::*;
(
  input wire logic clk,
  input wire logic rst_b,
  input wire logic cmd_valid,
  input wire logic [3:0] cmd_code,
  input wire logic [3:0] cmd_addr,
  input wire logic async_load_pin_b,
  output logic [3:0] ch_down,
  output logic [3:0] ch_settled,
  output logic [3:0] ch_update,
  output logic bias_down,
  output logic ref_down,
  output logic ref_by_ext
);
  import qdp_pkg::*;

  // ==========================================================
  // address decode, shared by power-down and update paths
  function automatic logic [3:0] qdp_sel(input logic [3:0] a);
    logic [3:0] s;
    s = 4'h0;
    if (a == QDP_ADDR_ALL)
    begin
      s = 4'hf;
    end
    else if (a < 4'h4)
    begin
      s[a[1:0]] = 1'b1;
    end
    return s;
  endfunction : qdp_sel

  // one command strobe compare, shared by every reference command branch but not the update wake branch
  function automatic logic qdp_hit(input logic v, input logic [3:0] c, input logic [3:0] w);
    return v && (c == w);
  endfunction : qdp_hit

  logic [2:0] load_sync_q;
  logic load_lvl_q;
  logic [3:0] pd_q;
  logic ref_down_q;
  logic ref_by_ext_q;
  logic [3:0] upd_q;
  logic [3:0] sel;
  logic [3:0] upd_mask;
  logic [3:0] pd_mask;
  logic load_fall;
  logic load_agree;
  logic ref_int_cmd;
  logic ref_ext_cmd;
  logic chip_pd_cmd;
  logic long_wait;

  // ==========================================================
  // load pin synchroniser; stage 0 feeds only stage 1
  // reset to the pin's idle high level so a release gives no false load edge
  always_ff @(posedge clk or negedge rst_b)
  begin
    if (!rst_b)
    begin
      load_sync_q <= QDP_SYNC_RST;
    end
    else
    begin
      load_sync_q <= {load_sync_q[1:0], async_load_pin_b};
    end
  end

  // level changes only once stages 1 and 2 agree
  assign load_agree = (load_sync_q[1] == load_sync_q[2]);

  always_ff @(posedge clk or negedge rst_b)
  begin
    if (!rst_b)
    begin
      load_lvl_q <= 1'b1;
    end
    else if (load_agree)
    begin
      load_lvl_q <= load_sync_q[2];
    end
  end
  assign load_fall = load_lvl_q && load_agree && !load_sync_q[2];

  // ==========================================================
  // command decode; data word never looked at here
  assign sel = qdp_sel(cmd_addr);

  always_comb
  begin
    upd_mask = 4'h0;
    pd_mask = 4'h0;
    if (cmd_valid)
    begin
      case (cmd_code)
        QDP_CMD_UPD_N: upd_mask = sel;
        QDP_CMD_WR_UPD_N: upd_mask = sel;
        QDP_CMD_WR_UPD_ALL: upd_mask = 4'hf;
        QDP_CMD_PD_N: pd_mask = sel;
        QDP_CMD_PD_CHIP: pd_mask = 4'hf;
        default: pd_mask = 4'h0;
      endcase
    end
    // a load pin event wakes every channel, like an update-all command
    if (load_fall)
    begin
      upd_mask = 4'hf;
    end
  end

  // bias is off only when everything, reference included, was down
  assign long_wait = (pd_q == 4'hf) && ref_down_q;

  // ==========================================================
  // reference command strobes
  assign ref_int_cmd = qdp_hit(cmd_valid, cmd_code, QDP_CMD_REF_INT);
  assign ref_ext_cmd = qdp_hit(cmd_valid, cmd_code, QDP_CMD_REF_EXT);
  assign chip_pd_cmd = qdp_hit(cmd_valid, cmd_code, QDP_CMD_PD_CHIP);

  // ==========================================================
  // channel power state; update wins over a same-cycle power-down
  always_ff @(posedge clk or negedge rst_b)
  begin
    if (!rst_b)
    begin
      pd_q <= QDP_PD_RST;
    end
    else
    begin
      pd_q <= (pd_q | pd_mask) & ~upd_mask;
    end
  end

  // update strobe to the register file; power-down never touches data
  always_ff @(posedge clk or negedge rst_b)
  begin
    if (!rst_b)
    begin
      upd_q <= 4'h0;
    end
    else
    begin
      upd_q <= upd_mask;
    end
  end

  // ==========================================================
  // reference state and the record of what turned it off
  always_ff @(posedge clk or negedge rst_b)
  begin
    if (!rst_b)
    begin
      ref_down_q <= !QDP_REF_ON_RST;
      ref_by_ext_q <= QDP_REF_BY_EXT_RST;
    end
    else if (ref_int_cmd)
    begin
      ref_down_q <= 1'b0;
      ref_by_ext_q <= 1'b0;
    end
    else if (ref_ext_cmd)
    begin
      ref_down_q <= 1'b1;
      ref_by_ext_q <= 1'b1;
    end
    else if (chip_pd_cmd)
    begin
      ref_down_q <= 1'b1;
      ref_by_ext_q <= 1'b0;
    end
    else if (ref_down_q && !ref_by_ext_q && (upd_mask != 4'h0))
    begin
      ref_down_q <= 1'b0;
    end
    // an external select keeps the reference off through updates
  end

  // ==========================================================
  // per-channel settle timers
  // a power-down during a wake clears the count, so settled reads high while down
  genvar gi;
  generate
    for (gi = 0; gi < QDP_NCH; gi++)
    begin : g_ch
      qdp_wake_timer u_tmr (
        .clk(clk),
        .rst_b(rst_b),
        .start(upd_mask[gi] && pd_q[gi]),
        .long_wait(long_wait),
        .abort(pd_mask[gi] && !upd_mask[gi]),
        .settled(ch_settled[gi])
      );
    end
  endgenerate

  // ==========================================================
  // outputs
  assign ch_down = pd_q;
  assign ch_update = upd_q;
  assign bias_down = (pd_q == 4'hf) && ref_down_q;
  assign ref_down = ref_down_q;
  assign ref_by_ext = ref_by_ext_q;
endmodule : qdp_power_ctrl

// ==== qdp_monitor.sv ====
/* qdp_monitor: port assertions for qdp_power_ctrl.
   assumes binding to the dut and no load edge next to a command. */
`timescale 1ns/1ps
module qdp_monitor
  import qdp_pkg::*;
(
  input wire logic clk,
  input wire logic rst_b,
  input wire logic cmd_valid,
  input wire logic [3:0] cmd_code,
  input wire logic [3:0] cmd_addr,
  input wire logic async_load_pin_b,
  input wire logic [3:0] ch_down,
  input wire logic [3:0] ch_settled,
  input wire logic [3:0] ch_update,
  input wire logic bias_down,
  input wire logic ref_down,
  input wire logic ref_by_ext
);
  default clocking @(posedge clk); endclocking
  default disable iff (!rst_b);
  logic [10:0] low_q;
  logic long_q;
  // ==========================================================
  // helper: channel 0 wait length and whether bias was off
  always_ff @(posedge clk or negedge rst_b)
    if (!rst_b) low_q <= '0;
    else low_q <= ch_settled[0] ? '0 : low_q + 11'h001;
  always_ff @(posedge clk or negedge rst_b)
    if (!rst_b) long_q <= 1'b0;
    else if ($fell(ch_settled[0])) long_q <= $past(bias_down);
  sequence s_cmd(logic [3:0] c);
    cmd_valid && cmd_code == c && async_load_pin_b;
  endsequence
  // ==========================================================
  // checks
  pd_all_a: assert property (s_cmd(QDP_CMD_PD_N) ##0 cmd_addr == QDP_ADDR_ALL
    |=> ch_down == 4'hf) else $error("power-down all failed");
  upd_wake_a: assert property (s_cmd(QDP_CMD_UPD_N) ##0 cmd_addr == 4'h0
    |=> !ch_down[0] && ch_update[0]) else $error("update did not wake");
  settle_len_a: assert property ($rose(ch_settled[0]) && !ch_down[0] |->
    low_q == (long_q ? QDP_WAKE_LONG_CYC : QDP_WAKE_SHORT_CYC)) else $error("wake length");
  bias_a: assert property (bias_down == (&ch_down && ref_down)) else $error("bias");
  ext_off_a: assert property (s_cmd(QDP_CMD_REF_EXT) |=> ref_down && ref_by_ext)
    else $error("ext select");
  ext_hold_a: assert property (ref_down && ref_by_ext &&
    !(cmd_valid && cmd_code == QDP_CMD_REF_INT) |=> ref_down) else $error("ref woke");
  chip_off_a: assert property (s_cmd(QDP_CMD_PD_CHIP) |=>
    ch_down == 4'hf && ref_down && !ref_by_ext) else $error("chip power-down");
  int_on_a: assert property (s_cmd(QDP_CMD_REF_INT) |=> !ref_down && !ref_by_ext)
    else $error("int select");
  load_wake_a: assert property ($fell(async_load_pin_b) |-> ##[2:5] ch_down == 4'h0)
    else $error("load pin wake");
endmodule : qdp_monitor
bind qdp_power_ctrl qdp_monitor mon_u (.clk(clk), .rst_b(rst_b), .cmd_valid(cmd_valid),
  .cmd_code(cmd_code), .cmd_addr(cmd_addr), .async_load_pin_b(async_load_pin_b),
  .ch_down(ch_down), .ch_settled(ch_settled), .ch_update(ch_update),
  .bias_down(bias_down), .ref_down(ref_down), .ref_by_ext(ref_by_ext));

// ==== qdp_cmd_src.sv ====
/* qdp_cmd_src: bus master side, one pulse per decoded command, load pin.
   assumes the caller waits for returns before the next request. */
`timescale 1ns/1ps
module qdp_cmd_src
  import qdp_pkg::*;
(
  input wire logic clk,
  output logic cmd_valid,
  output logic [3:0] cmd_code,
  output logic [3:0] cmd_addr,
  output logic async_load_pin_b
);
  // ==========================================================
  // drivers
  initial
  begin
    cmd_valid = 1'b0;
    cmd_code = QDP_CMD_NOP;
    cmd_addr = 4'h0;
    async_load_pin_b = 1'b1;
  end
  task automatic send(input logic [3:0] c, input logic [3:0] a);
    @(posedge clk);
    #1;
    cmd_valid = 1'b1;
    cmd_code = c;
    cmd_addr = a;
    @(posedge clk);
    #1;
    cmd_valid = 1'b0;
    // stale fields flip so nothing relies on them after release
    cmd_code = ~c;
    cmd_addr = ~a;
  endtask : send
  task automatic pulse_load;
    @(posedge clk);
    #1;
    async_load_pin_b = 1'b0;
    repeat (6) @(posedge clk);
    #1;
    async_load_pin_b = 1'b1;
  endtask : pulse_load
endmodule : qdp_cmd_src

// ==== qdp_power_ctrl_tb_top.sv ====
/* qdp_power_ctrl_tb_top: directed scenarios for the power control.
   assumes qdp_cmd_src as command master. */
`timescale 1ns/1ps
module qdp_power_ctrl_tb_top;
  import qdp_pkg::*;
  logic clk = 1'b0;
  logic rst_b = 1'b0;
  logic cmd_valid, async_load_pin_b, bias_down, ref_down, ref_by_ext;
  logic [3:0] cmd_code, cmd_addr, ch_down, ch_settled, ch_update;
  int n_fail = 0;
  int check_count = 0;
  logic [15:0] n;
  always #5 clk = ~clk;
  qdp_cmd_src src_u (.clk(clk), .cmd_valid(cmd_valid), .cmd_code(cmd_code),
    .cmd_addr(cmd_addr), .async_load_pin_b(async_load_pin_b));
  qdp_power_ctrl dut_u (.clk(clk), .rst_b(rst_b), .cmd_valid(cmd_valid), .cmd_code(cmd_code),
    .cmd_addr(cmd_addr), .async_load_pin_b(async_load_pin_b), .ch_down(ch_down),
    .ch_settled(ch_settled), .ch_update(ch_update), .bias_down(bias_down),
    .ref_down(ref_down), .ref_by_ext(ref_by_ext));
  // ==========================================================
  // helpers
  task automatic check(input logic [15:0] seen, input logic [15:0] exp);
    check_count++;
    if (seen !== exp)
    begin
      n_fail++;
      $display("MISMATCH t=%0t seen=%h exp=%h", $time, seen, exp);
    end
  endtask : check
  task automatic wait_settle;
    n = 16'h0000;
    while (ch_settled[0] !== 1'b1 && n < 16'h0800)
    begin
      @(posedge clk);
      #1;
      n++;
    end
  endtask : wait_settle
  task automatic final_report;
    $display("checks %0d mismatches %0d", check_count, n_fail);
    if (n_fail == 0 && check_count > 0) $display("Regression OK");
    else $display("Regression broken");
    $finish;
  endtask : final_report
  // ==========================================================
  // scenarios
  task automatic t_pd_wake;
    check(16'({ch_down, ch_settled, ref_down, bias_down}), 16'h003c);
    src_u.send(QDP_CMD_PD_N, 4'h0);
    src_u.send(QDP_CMD_PD_N, 4'h1);
    src_u.send(QDP_CMD_PD_N, 4'h5);
    src_u.send(QDP_CMD_WR_IN, 4'h1);
    check(16'(ch_down), 16'h0003);
    check(16'(ch_update), 16'h0000);
    src_u.send(QDP_CMD_UPD_N, 4'h0);
    check(16'({ch_down, ch_update, ch_settled}), 16'h021e);
    wait_settle();
    check(n, 16'(QDP_WAKE_SHORT_CYC));
    src_u.send(QDP_CMD_WR_UPD_N, 4'h1);
    check(16'({ch_down, ch_update}), 16'h0002);
    $display("end t_pd_wake");
  endtask : t_pd_wake
  task automatic t_ext;
    src_u.send(QDP_CMD_REF_EXT, 4'h0);
    src_u.send(QDP_CMD_PD_N, QDP_ADDR_ALL);
    check(16'({ref_down, ref_by_ext, bias_down}), 16'h0007);
    src_u.pulse_load();
    check(16'({ch_down, ref_down}), 16'h0001);
    src_u.send(QDP_CMD_REF_INT, 4'h0);
    check(16'({ref_down, ref_by_ext}), 16'h0000);
    $display("end t_ext");
  endtask : t_ext
  task automatic t_chip;
    repeat (1300) @(posedge clk);
    src_u.send(QDP_CMD_PD_CHIP, 4'h0);
    check(16'({ch_down, ref_down, ref_by_ext, bias_down}), 16'h007d);
    src_u.send(QDP_CMD_WR_UPD_ALL, 4'h0);
    check(16'({ch_down, ref_down}), 16'h0000);
    wait_settle();
    check(n, 16'(QDP_WAKE_LONG_CYC));
    $display("end t_chip");
  endtask : t_chip
  initial
  begin
    repeat (2) @(posedge clk);
    #1;
    rst_b = 1'b1;
    t_pd_wake();
    t_ext();
    t_chip();
    final_report();
  end
  initial
  begin
    #100000;
    n_fail++;
    final_report();
  end
endmodule : qdp_power_ctrl_tb_top
